/* File: design/dsts_seq.v */
// Drive self-test sequencer with a 20-entry results log
// Functional notes
// - Byte 1 bits 7:5: 001 short, 010 extended
// - Each run: electrical, servo, read/verify segments
// - Short test capped at 120 s, partial scan
// - Short test flags only functional failures
// - Extended: seeks, write check, full scan
// - Extended duration reported on an output
// - New entry at head, older shift down
// - Keep 20 entries, drop the oldest
// - New entry: function code, result Fh, save
// - Finish or abort overwrites entry result
// - Result 4 bits, zero pass, else reason
// - Failure records LBA, key, ASC, ASCQ, FRU
// - Bus or device reset aborts running test
// - Abort code gives result 01
// - Other aborts give result 02
// - Only unrecovered errors count as failures
`timescale 1ns/1ps
`include "dsts_consts.vh"
module dsts_seq #(
  parameter [39:0] SHORT_BUDGET = `DSTS_SHORT_CYCLES
) (
  input wire CLK,
  input wire RST,
  input wire CMD_VALID,
  input wire [7:0] CMD_BYTE1,
  input wire BUS_RESET,
  input wire DEV_RESET,
  input wire SEG_DONE,
  input wire SEG_ERR,
  input wire SEG_RECOVERED,
  input wire [31:0] SEG_LBA,
  input wire [3:0] SEG_KEY,
  input wire [7:0] SEG_ASC,
  input wire [7:0] SEG_ASCQ,
  input wire [7:0] SEG_FRU,
  input wire [4:0] LOG_INDEX,
  output reg [75:0] LOG_ENTRY,
  output reg [4:0] LOG_COUNT,
  output reg BUSY,
  output reg [2:0] SEG_START,
  output reg SCAN_FULL,
  output reg CMD_ACCEPT,
  output reg CMD_ILLEGAL,
  output reg NV_SAVE,
  output reg [15:0] EXT_DURATION
);
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_ELEC = 5'h02;
  localparam [4:0] ST_SERVO = 5'h04;
  localparam [4:0] ST_SCAN = 5'h08;
  localparam [4:0] ST_END = 5'h10;

  reg [75:0] log_mem [0:`DSTS_LOG_DEPTH-1];
  reg [4:0] state_reg;
  reg [4:0] state_next;
  reg [2:0] fc_reg;
  reg [3:0] res_reg;
  reg [3:0] res_next;
  reg [39:0] timer_reg;
  wire bus_rst_s;
  wire dev_rst_s;
  wire [2:0] fc_in;
  wire is_test;
  wire is_abort;
  wire reset_abort;
  wire host_abort;
  wire seg_fail;
  wire budget_out;
  integer i;

  dsts_sync u_sync_bus (
    .clk(CLK),
    .d(BUS_RESET),
    .q(bus_rst_s)
  );
  dsts_sync u_sync_dev (
    .clk(CLK),
    .d(DEV_RESET),
    .q(dev_rst_s)
  );

  assign fc_in = CMD_BYTE1[`DSTS_FC_MSB:`DSTS_FC_LSB];
  assign is_test = (fc_in == `DSTS_FC_SHORT) || (fc_in == `DSTS_FC_EXT);
  assign is_abort = (fc_in == `DSTS_FC_ABORT);
  assign reset_abort = bus_rst_s | dev_rst_s;
  assign host_abort = CMD_VALID & is_abort & (state_reg != ST_IDLE);
  assign seg_fail = SEG_DONE & SEG_ERR & ~SEG_RECOVERED;
  assign budget_out = (fc_reg == `DSTS_FC_SHORT) && (timer_reg >= SHORT_BUDGET);

  always @* begin
    state_next = state_reg;
    res_next = res_reg;
    case (state_reg)
      ST_IDLE: begin
        if (CMD_VALID && is_test && !reset_abort) begin
          state_next = ST_ELEC;
          res_next = `DSTS_RES_RUNNING;
        end
      end
      ST_ELEC, ST_SERVO, ST_SCAN: begin
        if (reset_abort) begin
          res_next = `DSTS_RES_RESET;
          state_next = ST_END;
        end else if (host_abort) begin
          res_next = `DSTS_RES_ABORTED;
          state_next = ST_END;
        end else if (budget_out) begin
          // Budget exhausted counts as a pass of the portions covered
          res_next = `DSTS_RES_PASS;
          state_next = ST_END;
        end else if (seg_fail) begin
          // only real failures
          // Segment index 0, 1, 2 from the one-hot state gives codes 7, 6, 5
          res_next = `DSTS_RES_SEG_FAIL - {2'b00, state_reg[3], state_reg[2]};
          state_next = ST_END;
        end else if (SEG_DONE) begin
          if (state_reg == ST_ELEC) begin
            state_next = ST_SERVO;
          end else if (state_reg == ST_SERVO) begin
            state_next = ST_SCAN;
          end else begin
            res_next = `DSTS_RES_PASS;
            state_next = ST_END;
          end
        end
      end
      ST_END: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always @(posedge CLK) begin
    if (RST) begin
      state_reg <= ST_IDLE;
      res_reg <= `DSTS_RES_PASS;
      fc_reg <= 3'h0;
      timer_reg <= 40'h0;
      LOG_COUNT <= 5'h00;
      LOG_ENTRY <= 76'h0;
      BUSY <= 1'b0;
      SEG_START <= 3'h0;
      SCAN_FULL <= 1'b0;
      CMD_ACCEPT <= 1'b0;
      CMD_ILLEGAL <= 1'b0;
      NV_SAVE <= 1'b0;
      EXT_DURATION <= 16'h0000;
      for (i = 0; i < `DSTS_LOG_DEPTH; i = i + 1) begin
        log_mem[i] <= 76'h0;
      end
    end else begin
      state_reg <= state_next;
      res_reg <= res_next;
      EXT_DURATION <= `DSTS_EXT_MINUTES;
      LOG_ENTRY <= (LOG_INDEX < `DSTS_LOG_DEPTH) ? log_mem[LOG_INDEX] : 76'h0;
      BUSY <= (state_next != ST_IDLE) && (state_next != ST_END);
      SCAN_FULL <= (fc_reg == `DSTS_FC_EXT);
      SEG_START <= 3'h0;
      NV_SAVE <= 1'b0;
      CMD_ACCEPT <= 1'b0;
      CMD_ILLEGAL <= 1'b0;
      timer_reg <= (state_reg == ST_IDLE) ? 40'h0 : timer_reg + 40'h1;
      if (state_reg == ST_IDLE && CMD_VALID) begin
        // reject unknown codes; abort while idle is accepted harmlessly
        CMD_ILLEGAL <= ~is_test & ~is_abort;
        CMD_ACCEPT <= (is_test & ~reset_abort) | is_abort;
      end else if (CMD_VALID && state_reg != ST_IDLE) begin
        CMD_ACCEPT <= is_abort;
        CMD_ILLEGAL <= ~is_abort;
      end
      if (state_reg == ST_IDLE && state_next == ST_ELEC) begin
        fc_reg <= fc_in;
        SCAN_FULL <= (fc_in == `DSTS_FC_EXT);
        SEG_START <= 3'h1;
        for (i = `DSTS_LOG_DEPTH - 1; i > 0; i = i - 1) begin
          log_mem[i] <= log_mem[i-1];
        end
        log_mem[0] <= {fc_in, 1'b0, `DSTS_RES_RUNNING, 8'h00, 60'h0};
        if (LOG_COUNT != `DSTS_LOG_DEPTH) begin
          LOG_COUNT <= LOG_COUNT + 5'h01;
        end
        NV_SAVE <= 1'b1;
      end
      if (SEG_DONE && state_next == ST_SERVO) begin
        SEG_START <= 3'h2;
      end
      if (SEG_DONE && state_next == ST_SCAN) begin
        SEG_START <= 3'h4;
      end
      if (state_reg != ST_IDLE && state_reg != ST_END && state_next == ST_END) begin
        log_mem[0][71:68] <= res_next;
        if (seg_fail && !reset_abort && !host_abort && !budget_out) begin
          log_mem[0][59:0] <= {SEG_LBA, SEG_KEY, SEG_ASC, SEG_ASCQ, SEG_FRU};
        end
        NV_SAVE <= 1'b1;
      end
    end
  end
endmodule

/* File: design/dsts_consts.vh */
// Constants for the drive self-test sequencer
`ifndef DSTS_CONSTS_VH
`define DSTS_CONSTS_VH
`define DSTS_FC_SHORT 3'h1
`define DSTS_FC_EXT 3'h2
`define DSTS_FC_ABORT 3'h4
`define DSTS_FC_MSB 7
`define DSTS_FC_LSB 5
`define DSTS_RES_PASS 4'h0
`define DSTS_RES_ABORTED 4'h1
`define DSTS_RES_RESET 4'h2
`define DSTS_RES_SEG_FAIL 4'h7
`define DSTS_RES_RUNNING 4'hf
`define DSTS_LOG_DEPTH 20
`define DSTS_SHORT_LIMIT_S 40'd120
`define DSTS_CLK_HZ 40'd125000000
`define DSTS_SHORT_CYCLES (`DSTS_SHORT_LIMIT_S * `DSTS_CLK_HZ)
`define DSTS_EXT_MINUTES 16'h005a
`define DSTS_ENTRY_W 76
`endif

/* File: design/dsts_sync.v */
// Two-flop synchroniser for a single level
`timescale 1ns/1ps
module dsts_sync (
  input wire clk,
  input wire d,
  output reg q
);
  reg meta_reg;
  always @(posedge clk) begin
    meta_reg <= d;
    q <= meta_reg;
  end
endmodule

/* File: test/dsts_host_model.sv */
// Host initiator model that issues diagnostic requests
`timescale 1ns/1ps
module dsts_host_model (
  input wire CLK,
  output reg CMD_VALID = 1'b0,
  output reg [7:0] CMD_BYTE1 = 8'h00
);
  task send(input [2:0] fc);
    @(negedge CLK);
    CMD_VALID = 1'b1;
    CMD_BYTE1 = {fc, 5'h1a};
    @(negedge CLK);
    CMD_VALID = 1'b0;
    // Junk once released, so a stale code cannot pass unseen
    CMD_BYTE1 = ~CMD_BYTE1;
  endtask
endmodule

/* File: test/dsts_seq_properties.sv */
// Port assertions for the self-test sequencer
`timescale 1ns/1ps
module dsts_seq_properties (
  input wire CLK,
  input wire RST,
  input wire CMD_VALID,
  input wire [7:0] CMD_BYTE1,
  input wire [4:0] LOG_COUNT,
  input wire BUSY,
  input wire [2:0] SEG_START,
  input wire CMD_ACCEPT,
  input wire CMD_ILLEGAL,
  input wire NV_SAVE
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  wire [2:0] fc = CMD_BYTE1[7:5];
  wire tst = fc == 3'h1 || fc == 3'h2;
  start_ok_a: assert property (CMD_VALID && !BUSY && tst |=> CMD_ACCEPT && NV_SAVE)
    else $error("start not answered");
  bad_code_a: assert property (CMD_VALID && !tst && fc != 3'h4 |=> CMD_ILLEGAL)
    else $error("bad code taken");
  busy_refuse_a: assert property (CMD_VALID && BUSY && tst |=> CMD_ILLEGAL)
    else $error("second test taken");
  count_cap_a: assert property (LOG_COUNT <= 5'd20)
    else $error("log count over cap");
  count_step_a: assert property ($rose(BUSY) |->
    LOG_COUNT == $past(LOG_COUNT) + {4'h0, $past(LOG_COUNT) != 5'd20})
    else $error("log count step wrong");
  end_save_a: assert property ($fell(BUSY) |-> NV_SAVE)
    else $error("end not saved");
  seg_one_a: assert property (SEG_START != 3'h0 |-> $onehot(SEG_START) && BUSY)
    else $error("segment start bad");
  first_seg_a: assert property ($rose(BUSY) |-> SEG_START == 3'h1)
    else $error("electrical not first");
  abort_end_a: assert property (CMD_VALID && BUSY && fc == 3'h4 |-> ##[1:3] !BUSY)
    else $error("abort ignored");
endmodule
bind dsts_seq dsts_seq_properties dsts_seq_properties_i (.CLK(CLK), .RST(RST),
  .CMD_VALID(CMD_VALID), .CMD_BYTE1(CMD_BYTE1), .LOG_COUNT(LOG_COUNT), .BUSY(BUSY),
  .SEG_START(SEG_START), .CMD_ACCEPT(CMD_ACCEPT), .CMD_ILLEGAL(CMD_ILLEGAL), .NV_SAVE(NV_SAVE));

/* File: test/dsts_seq_tb.sv */
// Self-checking bench for the self-test sequencer
`timescale 1ns/1ps
module dsts_seq_tb;
  reg CLK = 0, RST = 1, BUS_RESET = 0, DEV_RESET = 0, SEG_DONE = 0, SEG_ERR = 0, SEG_RECOVERED = 0;
  reg [4:0] LOG_INDEX = 5'h0;
  reg [31:0] SEG_LBA = 32'h0;
  wire CMD_VALID, BUSY, SCAN_FULL, CMD_ACCEPT, CMD_ILLEGAL, NV_SAVE;
  wire [7:0] CMD_BYTE1;
  wire [75:0] LOG_ENTRY;
  wire [4:0] LOG_COUNT;
  wire [2:0] SEG_START;
  wire [15:0] EXT_DURATION;
  integer err_count = 0, check_count = 0, cyc = 0, k;
  dsts_host_model dsts_host_model_i (.CLK(CLK), .CMD_VALID(CMD_VALID), .CMD_BYTE1(CMD_BYTE1));
  // Short budget cut to 50 cycles so the time limit can be reached
  dsts_seq #(.SHORT_BUDGET(40'd50)) dsts_seq_i (.CLK(CLK), .RST(RST), .CMD_VALID(CMD_VALID),
    .CMD_BYTE1(CMD_BYTE1), .BUS_RESET(BUS_RESET), .DEV_RESET(DEV_RESET), .SEG_DONE(SEG_DONE),
    .SEG_ERR(SEG_ERR), .SEG_RECOVERED(SEG_RECOVERED), .SEG_LBA(SEG_LBA), .SEG_KEY(4'h3),
    .SEG_ASC(8'h11), .SEG_ASCQ(8'h04), .SEG_FRU(8'h81), .LOG_INDEX(LOG_INDEX),
    .LOG_ENTRY(LOG_ENTRY), .LOG_COUNT(LOG_COUNT), .BUSY(BUSY), .SEG_START(SEG_START),
    .SCAN_FULL(SCAN_FULL), .CMD_ACCEPT(CMD_ACCEPT), .CMD_ILLEGAL(CMD_ILLEGAL), .NV_SAVE(NV_SAVE),
    .EXT_DURATION(EXT_DURATION));
  initial begin
    forever #4 CLK = ~CLK;
  end
  always @(posedge CLK) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      err_count = err_count + 1;
      end_of_test;
    end
  end
  task end_of_test;
    if (err_count == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task chk(input [75:0] s, input [75:0] e);
    check_count = check_count + 1;
    if (s !== e) begin
      err_count = err_count + 1;
      $display("BAD %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task go(input [2:0] fc, input acc);
    dsts_host_model_i.send(fc);
    // Answer pulses stand for one cycle only, so look right after the request
    chk({CMD_ACCEPT, CMD_ILLEGAL}, {acc, !acc});
  endtask
  task seg(input [2:0] s, input err, input rec);
    chk(SEG_START, s);
    @(negedge CLK);
    {SEG_DONE, SEG_ERR, SEG_RECOVERED} = {1'b1, err, rec};
    @(negedge CLK);
    SEG_DONE = 1'b0;
  endtask
  task rd(input [4:0] i, input [2:0] fc, input [3:0] r);
    LOG_INDEX = i;
    repeat (2) @(negedge CLK);
    chk(LOG_ENTRY[75:68], {fc, 1'b0, r});
  endtask
  initial begin
    repeat (2) @(negedge CLK);
    RST = 1'b0;
    @(negedge CLK);
    chk(EXT_DURATION, 16'h005a);
    chk(BUSY, 1'b0);
    go(3'h1, 1'b1);
    chk(NV_SAVE, 1'b1);
    seg(3'h1, 1'b0, 1'b0);
    seg(3'h2, 1'b0, 1'b0);
    seg(3'h4, 1'b0, 1'b0);
    chk(NV_SAVE, 1'b1);
    rd(5'h0, 3'h1, 4'h0);
    go(3'h2, 1'b1);
    chk(SCAN_FULL, 1'b1);
    seg(3'h1, 1'b0, 1'b0);
    seg(3'h2, 1'b1, 1'b1);
    SEG_LBA = 32'h0001_2345;
    seg(3'h4, 1'b1, 1'b0);
    rd(5'h0, 3'h2, 4'h5);
    chk(LOG_ENTRY[59:0], {32'h0001_2345, 4'h3, 8'h11, 8'h04, 8'h81});
    go(3'h4, 1'b1);
    go(3'h2, 1'b1);
    go(3'h1, 1'b0);
    go(3'h4, 1'b1);
    rd(5'h0, 3'h2, 4'h1);
    for (k = 0; k < 2; k = k + 1) begin
      go(3'h1, 1'b1);
      {BUS_RESET, DEV_RESET} = {k == 0, k == 1};
      repeat (3) @(negedge CLK);
      {BUS_RESET, DEV_RESET} = 2'b00;
      repeat (4) @(negedge CLK);
      rd(5'h0, 3'h1, 4'h2);
    end
    go(3'h1, 1'b1);
    repeat (40) @(negedge CLK);
    chk(BUSY, 1'b1);
    repeat (20) @(negedge CLK);
    rd(5'h0, 3'h1, 4'h0);
    for (k = 0; k < 8; k = k + 1)
      if (k != 1 && k != 2 && k != 4)
        go(k[2:0], 1'b0);
    chk(LOG_COUNT, 5'h6);
    for (k = 0; k < 16; k = k + 1) begin
      go(3'h1, 1'b1);
      go(3'h4, 1'b1);
    end
    chk(LOG_COUNT, 5'd20);
    rd(5'd19, 3'h2, 4'h1);
    rd(5'd16, 3'h1, 4'h0);
    rd(5'd20, 3'h0, 4'h0);
    end_of_test;
  end
endmodule
